// [design/mic_pkg.sv]
// Package: register map, reset values, source codes and sequence lengths
package mic_pkg;
   localparam int N_EXT = 4;
   localparam int N_WAKE = 6;
   localparam int N_PER = 8;
   localparam int N_SRC = 15;

   // Register byte offsets on the APB side
   localparam logic [7:0] OFS_EXT_EDGE = 8'h00;
   localparam logic [7:0] OFS_WAKE_EDGE = 8'h04;
   localparam logic [7:0] OFS_PORT_A = 8'h08;
   localparam logic [7:0] OFS_PORT_B = 8'h0c;
   localparam logic [7:0] OFS_EXT_FLAG = 8'h10;
   localparam logic [7:0] OFS_WAKE_FLAG = 8'h14;
   localparam logic [7:0] OFS_IRQ_EN = 8'h18;
   localparam logic [7:0] OFS_PER_FLAG = 8'h1c;
   localparam logic [7:0] OFS_PER_EN = 8'h20;
   localparam logic [7:0] OFS_BRK_CTRL = 8'h24;
   localparam logic [7:0] OFS_BRK_STAT = 8'h28;
   localparam logic [7:0] OFS_BRK_ADDR = 8'h2c;
   localparam logic [7:0] OFS_BRK_DATA = 8'h30;
   localparam logic [7:0] OFS_STATUS = 8'h34;

   // Field positions
   localparam int WAKE_EN_BIT = 5;
   localparam int BRK_DCMP_BIT = 2;
   localparam int BRK_EN_BIT = 7;
   localparam logic [1:0] WAKE_FLAG_RSVD = 2'h3;

   // Reset values
   localparam logic [3:0] RST_EXT = 4'h0;
   localparam logic [5:0] RST_WAKE = 6'h00;
   localparam logic [7:0] RST_PER = 8'h00;
   localparam logic [7:0] RST_BRK_CTRL = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic RST_I_MASK = 1'b1;

   // Source codes, lowest code wins arbitration
   localparam logic [3:0] SRC_NMI = 4'h0;
   localparam logic [3:0] SRC_BRK = 4'h1;
   localparam logic [3:0] SRC_EXT0 = 4'h2;
   localparam logic [3:0] SRC_WAKE = 4'h6;
   localparam logic [3:0] SRC_PER0 = 4'h7;

   // Vector table base, one word per source
   localparam logic [15:0] VEC_BASE = 16'h0010;

   // Exception sequence lengths in states (one state is one clock)
   localparam int STACK_STATES = 4;
   localparam int VEC_STATES = 2;
   localparam int FETCH_STATES = 4;
   localparam int INTERNAL_STATES = 4;
   localparam logic [2:0] CNT_ZERO = 3'h0;

   typedef enum logic [2:0] {
      MIC_IDLE, MIC_STACK, MIC_VECTOR, MIC_FETCH, MIC_INTERNAL
   } mic_state_e;
endpackage

// [design/mic_intc.sv]
// Interrupt controller with exception sequencer and APB register file
//
// Behaviour
// - Four external request pins, own vectors, per-pin rising or falling edge.
// - Enabled pin function plus selected edge sets that pin's flag.
// - Accepting an external pin request sets the global mask bit.
// - Each external request has its own enable bit.
// - Six wake-up pins share one vector, each with own edge select.
// - Enabled wake-up pin function plus selected edge sets its wake flag.
// - One common enable bit masks all six wake-up requests.
// - Peripheral request sets its flag; enable bit at zero masks it.
// - Request forwarded only if non-maskable or its enable bit is one.
// - Only the highest-priority request is presented; others stay pending.
// - NMI and break ignore mask bit; others need mask bit clear.
// - Accept at instruction end, then push PC and CONDITION_CODE_REG.
// - Mask bit set on acceptance, before stacking; return restores saved mask bit.
// - Fetch handler address from the source's vector, load PC.
// - Sequence takes 4 stacking, 2 vector, 4 fetch, 4 internal states.
// - After reset nothing, not even NMI, is accepted before first instruction.
// - Word accesses, stack included, force address bit zero to zero.
// - Break unit raises request when its programmed bus condition holds.
// - External and wake flags clear only by software writing zero.
// - NMI raised by falling edge on its pin, highest priority.
`timescale 1ns/10ps
`default_nettype none
module mic_intc (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic nmi_pin_n,
   input wire logic [mic_pkg::N_EXT-1:0] ext_req_pin,
   input wire logic [mic_pkg::N_WAKE-1:0] wake_pin,
   input wire logic [mic_pkg::N_PER-1:0] periph_req,
   input wire logic [15:0] bus_addr,
   input wire logic [15:0] bus_data,
   input wire logic bus_exec,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic instr_done,
   input wire logic [15:0] core_pc,
   input wire logic [7:0] core_ccr,
   input wire logic [15:0] core_sp,
   input wire logic rte_done,
   input wire logic rte_ccr_i,
   input wire logic ccr_i_wr,
   input wire logic ccr_i_val,
   input wire logic [15:0] vec_rdata,
   output logic i_mask,
   output logic exc_busy,
   output logic [3:0] active_src,
   output logic stack_we,
   output logic [15:0] stack_addr,
   output logic [15:0] stack_wdata,
   output logic vec_rd,
   output logic [15:0] vec_addr,
   output logic pc_load,
   output logic [15:0] pc_value
);
   import mic_pkg::*;

   // APB decode
   logic setup;
   logic access;
   logic wr;
   logic hit;
   logic [31:0] rd_mux;

   // Configuration
   logic [3:0] ext_edge_select_reg;
   logic [5:0] wake_edge_select_reg;
   logic [3:0] port_func_reg_a;
   logic [5:0] port_func_reg_b;
   logic [3:0] ext_enable_reg;
   logic wake_common_enable;
   logic [7:0] per_en_reg;
   logic [7:0] brk_ctrl_reg;
   logic [15:0] brk_addr_reg;
   logic [15:0] brk_data_reg;

   // Flags
   logic [3:0] ext_request_flag_reg;
   logic [3:0] ext_request_flag_next;
   logic [5:0] wake_flag_reg;
   logic [5:0] wake_flag_next;
   logic [7:0] per_flag_reg;
   logic [7:0] per_flag_next;
   logic brk_flag_reg;
   logic nmi_pend_reg;

   // Pin synchronisers, third stage for edge history
   logic [3:0] ext_s1, ext_s2, ext_s3;
   logic [5:0] wake_s1, wake_s2, wake_s3;
   logic nmi_s1, nmi_s2, nmi_s3;
   logic [3:0] ext_edge;
   logic [5:0] wake_edge;
   logic nmi_fall;
   logic brk_match;

   // Arbitration and sequencing
   logic [N_SRC-1:0] req;
   logic [N_SRC-1:0] eligible;
   logic any_req;
   logic [3:0] win_src;
   logic accept;
   logic boot_done_reg;
   logic i_mask_reg;
   mic_state_e state_reg;
   logic [2:0] cnt_reg;
   logic [3:0] src_reg;
   logic [15:0] sp_reg;
   logic [15:0] pc_save_reg;
   logic [7:0] ccr_save_reg;

   assign setup = psel & ~penable;
   assign access = psel & penable & pready;
   assign wr = access & pwrite & hit;

   always_comb begin
      hit = 1'b1;
      rd_mux = 32'h0;
      unique case (paddr)
         OFS_EXT_EDGE: rd_mux = {28'h0, ext_edge_select_reg};
         OFS_WAKE_EDGE: rd_mux = {26'h0, wake_edge_select_reg};
         OFS_PORT_A: rd_mux = {28'h0, port_func_reg_a};
         OFS_PORT_B: rd_mux = {26'h0, port_func_reg_b};
         OFS_EXT_FLAG: rd_mux = {28'h0, ext_request_flag_reg};
         OFS_WAKE_FLAG: rd_mux = {24'h0, WAKE_FLAG_RSVD, wake_flag_reg};
         OFS_IRQ_EN: rd_mux = {26'h0, wake_common_enable, 1'b0,
            ext_enable_reg};
         OFS_PER_FLAG: rd_mux = {24'h0, per_flag_reg};
         OFS_PER_EN: rd_mux = {24'h0, per_en_reg};
         OFS_BRK_CTRL: rd_mux = {24'h0, brk_ctrl_reg};
         OFS_BRK_STAT: rd_mux = {31'h0, brk_flag_reg};
         OFS_BRK_ADDR: rd_mux = {16'h0, brk_addr_reg};
         OFS_BRK_DATA: rd_mux = {16'h0, brk_data_reg};
         OFS_STATUS: rd_mux = {23'h0, boot_done_reg, src_reg, 2'h0,
            exc_busy, i_mask_reg};
         default: hit = 1'b0;
      endcase
   end

   // Zero wait state: pready rises in the first access cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~hit;
         if (setup) begin
            prdata <= (pwrite | ~hit) ? 32'h0 : rd_mux;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ext_edge_select_reg <= RST_EXT;
         wake_edge_select_reg <= RST_WAKE;
         port_func_reg_a <= RST_EXT;
         port_func_reg_b <= RST_WAKE;
         ext_enable_reg <= RST_EXT;
         wake_common_enable <= 1'b0;
         per_en_reg <= RST_PER;
         brk_ctrl_reg <= RST_BRK_CTRL;
         brk_addr_reg <= RST_WORD;
         brk_data_reg <= RST_WORD;
      end else if (wr) begin
         unique case (paddr)
            OFS_EXT_EDGE: ext_edge_select_reg <= pwdata[3:0];
            OFS_WAKE_EDGE: wake_edge_select_reg <= pwdata[5:0];
            OFS_PORT_A: port_func_reg_a <= pwdata[3:0];
            OFS_PORT_B: port_func_reg_b <= pwdata[5:0];
            OFS_IRQ_EN: begin
               ext_enable_reg <= pwdata[3:0];
               wake_common_enable <= pwdata[WAKE_EN_BIT];
            end
            OFS_PER_EN: per_en_reg <= pwdata[7:0];
            OFS_BRK_CTRL: brk_ctrl_reg <= pwdata[7:0];
            OFS_BRK_ADDR: brk_addr_reg <= pwdata[15:0];
            OFS_BRK_DATA: brk_data_reg <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Pins come from outside: two flops before any logic looks at them
   always_ff @(posedge clock) begin
      if (rst) begin
         ext_s1 <= 4'h0;
         ext_s2 <= 4'h0;
         ext_s3 <= 4'h0;
         wake_s1 <= 6'h00;
         wake_s2 <= 6'h00;
         wake_s3 <= 6'h00;
         nmi_s1 <= 1'b1;
         nmi_s2 <= 1'b1;
         nmi_s3 <= 1'b1;
      end else begin
         ext_s1 <= ext_req_pin;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         wake_s1 <= wake_pin;
         wake_s2 <= wake_s1;
         wake_s3 <= wake_s2;
         nmi_s1 <= nmi_pin_n;
         nmi_s2 <= nmi_s1;
         nmi_s3 <= nmi_s2;
      end
   end

   // Edge select 1 means rising edge
   assign ext_edge = port_func_reg_a &
      ((ext_edge_select_reg & ext_s2 & ~ext_s3) |
       (~ext_edge_select_reg & ~ext_s2 & ext_s3));
   assign wake_edge = port_func_reg_b &
      ((wake_edge_select_reg & wake_s2 & ~wake_s3) |
       (~wake_edge_select_reg & ~wake_s2 & wake_s3));
   assign nmi_fall = ~nmi_s2 & nmi_s3;

   // Break: exec at address, or read/write access with optional data match
   always_comb begin
      brk_match = 1'b0;
      if (bus_addr == brk_addr_reg) begin
         unique case (brk_ctrl_reg[1:0])
            2'h0: brk_match = bus_exec;
            2'h1: brk_match = bus_rd;
            2'h2: brk_match = bus_wr;
            2'h3: brk_match = bus_rd | bus_wr;
         endcase
         if (brk_ctrl_reg[1:0] != 2'h0 && brk_ctrl_reg[BRK_DCMP_BIT] &&
             bus_data != brk_data_reg) begin
            brk_match = 1'b0;
         end
      end
   end

   // Software clears by writing 0; a new edge in that cycle still sets
   always_comb begin
      ext_request_flag_next = ext_request_flag_reg;
      wake_flag_next = wake_flag_reg;
      per_flag_next = per_flag_reg;
      if (wr && paddr == OFS_EXT_FLAG) begin
         ext_request_flag_next = ext_request_flag_reg & pwdata[3:0];
      end
      if (wr && paddr == OFS_WAKE_FLAG) begin
         wake_flag_next = wake_flag_reg & pwdata[5:0];
      end
      if (wr && paddr == OFS_PER_FLAG) begin
         per_flag_next = per_flag_reg & pwdata[7:0];
      end
      ext_request_flag_next = ext_request_flag_next | ext_edge;
      wake_flag_next = wake_flag_next | wake_edge;
      per_flag_next = per_flag_next | periph_req;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ext_request_flag_reg <= RST_EXT;
         wake_flag_reg <= RST_WAKE;
         per_flag_reg <= RST_PER;
         brk_flag_reg <= 1'b0;
         nmi_pend_reg <= 1'b0;
      end else begin
         ext_request_flag_reg <= ext_request_flag_next;
         wake_flag_reg <= wake_flag_next;
         per_flag_reg <= per_flag_next;
         if (brk_match) begin
            brk_flag_reg <= 1'b1;
         end else if (wr && paddr == OFS_BRK_STAT && !pwdata[0]) begin
            brk_flag_reg <= 1'b0;
         end
         // NMI has no software flag; acceptance consumes it
         if (nmi_fall) begin
            nmi_pend_reg <= 1'b1;
         end else if (accept && win_src == SRC_NMI) begin
            nmi_pend_reg <= 1'b0;
         end
      end
   end

   // Flags stay presented until cleared or disabled
   assign req = {per_flag_reg & per_en_reg,
                 (|wake_flag_reg) & wake_common_enable,
                 ext_request_flag_reg & ext_enable_reg,
                 brk_flag_reg & brk_ctrl_reg[BRK_EN_BIT],
                 nmi_pend_reg};
   assign eligible = req & {{(N_SRC-2){~i_mask_reg}}, 2'h3};

   // Fixed priority: lowest code wins
   always_comb begin
      any_req = 1'b0;
      win_src = SRC_NMI;
      for (int k = N_SRC - 1; k >= 0; k--) begin
         if (eligible[k]) begin
            any_req = 1'b1;
            win_src = 4'(k);
         end
      end
   end

   // Only at an instruction boundary, never before the first one ends
   assign accept = (state_reg == MIC_IDLE) && instr_done && boot_done_reg &&
      any_req;

   always_ff @(posedge clock) begin
      if (rst) begin
         boot_done_reg <= 1'b0;
      end else if (instr_done) begin
         boot_done_reg <= 1'b1;
      end
   end

   // Acceptance outranks a return or a software write in the same cycle
   // Output copy shares the update so the pin never lags the arbiter
   always_ff @(posedge clock) begin
      if (rst) begin
         i_mask_reg <= RST_I_MASK;
         i_mask <= RST_I_MASK;
      end else if (accept) begin
         i_mask_reg <= 1'b1;
         i_mask <= 1'b1;
      end else if (rte_done) begin
         i_mask_reg <= rte_ccr_i;
         i_mask <= rte_ccr_i;
      end else if (ccr_i_wr) begin
         i_mask_reg <= ccr_i_val;
         i_mask <= ccr_i_val;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= MIC_IDLE;
         cnt_reg <= CNT_ZERO;
         src_reg <= SRC_NMI;
         sp_reg <= RST_WORD;
         pc_save_reg <= RST_WORD;
         ccr_save_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_reg + 3'h1;
         unique case (state_reg)
            MIC_IDLE: begin
               cnt_reg <= CNT_ZERO;
               if (accept) begin
                  state_reg <= MIC_STACK;
                  src_reg <= win_src;
                  sp_reg <= core_sp & 16'hfffe;
                  pc_save_reg <= core_pc;
                  ccr_save_reg <= core_ccr;
               end
            end
            MIC_STACK: begin
               if (cnt_reg == 3'(STACK_STATES - 1)) begin
                  state_reg <= MIC_VECTOR;
                  cnt_reg <= CNT_ZERO;
               end
            end
            MIC_VECTOR: begin
               if (cnt_reg == 3'(VEC_STATES - 1)) begin
                  state_reg <= MIC_FETCH;
                  cnt_reg <= CNT_ZERO;
               end
            end
            MIC_FETCH: begin
               if (cnt_reg == 3'(FETCH_STATES - 1)) begin
                  state_reg <= MIC_INTERNAL;
                  cnt_reg <= CNT_ZERO;
               end
            end
            MIC_INTERNAL: begin
               if (cnt_reg == 3'(INTERNAL_STATES - 1)) begin
                  state_reg <= MIC_IDLE;
                  cnt_reg <= CNT_ZERO;
               end
            end
         endcase
      end
   end

   // Bus side of the sequence, all outputs registered
   always_ff @(posedge clock) begin
      if (rst) begin
         stack_we <= 1'b0;
         stack_addr <= RST_WORD;
         stack_wdata <= RST_WORD;
         vec_rd <= 1'b0;
         vec_addr <= RST_WORD;
         pc_load <= 1'b0;
         pc_value <= RST_WORD;
         exc_busy <= 1'b0;
         active_src <= SRC_NMI;
      end else begin
         stack_we <= 1'b0;
         vec_rd <= 1'b0;
         pc_load <= 1'b0;
         exc_busy <= (state_reg != MIC_IDLE) || accept;
         active_src <= accept ? win_src : src_reg;
         if (state_reg == MIC_STACK && cnt_reg == CNT_ZERO) begin
            stack_we <= 1'b1;
            stack_addr <= sp_reg - 16'h0002;
            stack_wdata <= pc_save_reg;
         end
         if (state_reg == MIC_STACK && cnt_reg == 3'h2) begin
            stack_we <= 1'b1;
            stack_addr <= sp_reg - 16'h0004;
            stack_wdata <= {ccr_save_reg, ccr_save_reg};
         end
         if (state_reg == MIC_VECTOR && cnt_reg == CNT_ZERO) begin
            vec_rd <= 1'b1;
            vec_addr <= VEC_BASE + {11'h0, src_reg, 1'b0};
         end
         if (state_reg == MIC_VECTOR && cnt_reg == 3'h1) begin
            pc_value <= vec_rdata & 16'hfffe;
         end
         if (state_reg == MIC_INTERNAL &&
             cnt_reg == 3'(INTERNAL_STATES - 1)) begin
            pc_load <= 1'b1;
         end
      end
   end
endmodule // mic_intc
`default_nettype wire

// [tb/mic_core_model.sv]
// Behavioural CPU core: instruction boundaries, context and vector memory
`timescale 1ns/10ps
`default_nettype none
module mic_core_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic run,
   input wire logic exc_busy,
   input wire logic vec_rd,
   input wire logic [15:0] vec_addr,
   output logic instr_done,
   output logic [15:0] core_pc,
   output logic [7:0] core_ccr,
   output logic [15:0] core_sp,
   output logic [15:0] vec_rdata
);
   logic [1:0] cnt_reg;
   // Odd stack pointer makes the word alignment of pushes visible
   assign core_sp = 16'hff01;
   assign core_pc = 16'h1234;
   assign core_ccr = 8'h05;
   // Word traceable to its slot; inverted outside the read strobe
   assign vec_rdata = {8'h20, vec_addr[7:0]} ^ {16{!vec_rd}};
   // Instruction ends every fourth cycle, never inside the sequence
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_reg <= 2'h0;
         instr_done <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + 2'h1;
         instr_done <= run && !exc_busy && cnt_reg == 2'h3;
      end
   end
endmodule // mic_core_model
`default_nettype wire

// [tb/mic_intc_assertions.sv]
// Checker for the exception sequence and register bus timing
`timescale 1ns/10ps
`default_nettype none
module mic_intc_assertions (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic instr_done,
   input wire logic [15:0] core_pc,
   input wire logic [7:0] core_ccr,
   input wire logic [15:0] core_sp,
   input wire logic [15:0] vec_rdata,
   input wire logic i_mask,
   input wire logic exc_busy,
   input wire logic [3:0] active_src,
   input wire logic stack_we,
   input wire logic [15:0] stack_addr,
   input wire logic [15:0] stack_wdata,
   input wire logic vec_rd,
   input wire logic [15:0] vec_addr,
   input wire logic pc_load,
   input wire logic [15:0] pc_value
);
   import mic_pkg::*;
   logic armed_reg;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // First boundary after reset only arms acceptance
   always_ff @(posedge clock) begin
      if (rst) begin
         armed_reg <= 1'b0;
      end else if (instr_done) begin
         armed_reg <= 1'b1;
      end
   end
   sequence s_accept;
      $rose(exc_busy);
   endsequence
   sequence s_pushes;
      ##1 stack_we && stack_wdata == $past(core_pc, 2) &&
         stack_addr == ($past(core_sp, 2) & 16'hfffe) - 16'h0002
      ##2 stack_we && stack_wdata[7:0] == $past(core_ccr, 4) &&
         stack_wdata[15:8] == $past(core_ccr, 4) &&
         stack_addr == ($past(core_sp, 4) & 16'hfffe) - 16'h0004;
   endsequence
   chk_mask_on_accept: assert property (s_accept |-> i_mask)
      else $error("mask bit low after accept");
   chk_stack_pushes: assert property (s_accept |-> s_pushes)
      else $error("stack push wrong");
   chk_vector_addr: assert property (s_accept |-> ##5 vec_rd &&
      vec_addr == VEC_BASE + {11'h000, active_src, 1'b0})
      else $error("vector address wrong");
   chk_handler_load: assert property (vec_rd |=>
      pc_value == ($past(vec_rdata) & 16'hfffe))
      else $error("handler address wrong");
   chk_response_time: assert property (s_accept |->
      (exc_busy throughout ##14 pc_load) ##1 !exc_busy)
      else $error("sequence length wrong");
   chk_mask_blocks: assert property ($rose(exc_busy) && $past(i_mask) |->
      active_src <= SRC_BRK)
      else $error("maskable source taken while masked");
   chk_reset_guard: assert property (s_accept |-> $past(armed_reg))
      else $error("accept before first instruction");
   chk_apb_zero_wait: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
endmodule // mic_intc_assertions
`default_nettype wire
bind mic_intc mic_intc_assertions u_chk (.clock, .rst, .psel, .penable,
   .pready, .instr_done, .core_pc, .core_ccr, .core_sp, .vec_rdata, .i_mask,
   .exc_busy, .active_src, .stack_we, .stack_addr, .stack_wdata, .vec_rd,
   .vec_addr, .pc_load, .pc_value);

// [tb/mic_intc_tb_top.sv]
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module mic_intc_tb_top;
   import mic_pkg::*;
   typedef struct {logic grp; int idx; logic rise; logic fn; logic exp;} mic_row_s;
   // Group (1 wake), pin, rising edge, pin function on, flag expected
   mic_row_s rows [6] = '{'{0, 0, 1, 1, 1}, '{0, 3, 0, 1, 1}, '{0, 1, 1, 0, 0},
      '{1, 0, 1, 1, 1}, '{1, 5, 0, 1, 1}, '{1, 2, 0, 0, 0}};
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, err, run;
   logic nmi_pin_n, bus_exec, bus_rd, bus_wr, instr_done, rte_done, rte_ccr_i;
   logic ccr_i_wr, ccr_i_val, i_mask, exc_busy, stack_we, vec_rd, pc_load;
   logic [7:0] paddr, g, core_ccr;
   logic [31:0] pwdata, prdata, fx;
   logic [N_EXT-1:0] ext_req_pin;
   logic [N_WAKE-1:0] wake_pin;
   logic [N_PER-1:0] periph_req;
   logic [3:0] active_src;
   logic [15:0] bus_addr, bus_data, core_pc, core_sp, vec_rdata, stack_addr;
   logic [15:0] stack_wdata, vec_addr, pc_value, a0, a1, d0, d1;
   int miscompares = 0;
   int n_compared = 0;
   int nacc = 0;
   int i;
   always #2.5 clock = ~clock;
   mic_intc DUT (.*);
   mic_core_model u_core (.clock, .rst, .run, .exc_busy, .vec_rd, .vec_addr,
      .instr_done, .core_pc, .core_ccr, .core_sp, .vec_rdata);
   always @(posedge clock) begin
      if (pc_load === 1'b1) nacc <= nacc + 1;
      if (stack_we === 1'b1) begin
         a0 <= a1;
         d0 <= d1;
         a1 <= stack_addr;
         d1 <= stack_wdata;
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) miscompares++;
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(a, 1'b1, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(a, 1'b0, 32'h0, r);
      check(r, e);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task setpin(input logic v);
      @(posedge clock);
      if (rows[i].grp) wake_pin[rows[i].idx] <= v;
      else ext_req_pin[rows[i].idx] <= v;
   endtask
   task automatic unmask(input logic by_rte);
      @(posedge clock);
      rte_done <= by_rte;
      ccr_i_wr <= !by_rte;
      @(posedge clock);
      rte_done <= 1'b0;
      ccr_i_wr <= 1'b0;
   endtask
   task automatic idle_chk();
      int k;
      k = nacc;
      cyc(40);
      check(32'(nacc - k), 32'h0);
   endtask
   task automatic accept(input logic [3:0] src);
      int n;
      n = 0;
      while (pc_load !== 1'b1 && n < 200) begin
         @(posedge clock);
         n++;
      end
      check(32'(pc_load), 32'h1);
      check(32'(active_src), 32'(src));
      check(32'(i_mask), 32'h1);
      check({a0, d0}, {16'hfefe, 16'h1234});
      check({a1, d1}, {16'hfefc, 16'h0505});
      check(32'(pc_value), {16'h0, 8'h20, VEC_BASE[7:0] + {3'h0, src, 1'b0}});
      $display("accept of source %0d done", src);
   endtask
   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Whole run needs about 600 cycles
   initial begin
      #100000;
      miscompares++;
      summarize();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, run, err} = '0;
      {ext_req_pin, wake_pin, periph_req, bus_addr, bus_data} = '0;
      {bus_exec, bus_rd, bus_wr, rte_done, rte_ccr_i, ccr_i_wr, ccr_i_val} = '0;
      nmi_pin_n = 1'b1;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rd(OFS_STATUS, 32'h1);
      rd(OFS_WAKE_FLAG, 32'hc0);
      rd(8'h3c, 32'h0);
      check(32'(err), 32'h1);
      @(posedge clock);
      nmi_pin_n <= 1'b0;
      run <= 1'b1;
      accept(SRC_NMI);
      for (i = 0; i < 6; i++) begin
         g = rows[i].grp ? 8'h04 : 8'h00;
         fx = rows[i].grp ? 32'hc0 : 32'h0;
         wr(OFS_EXT_EDGE + g, 32'(rows[i].rise) << rows[i].idx);
         wr(OFS_PORT_A + g, 32'(rows[i].fn) << rows[i].idx);
         setpin(!rows[i].rise);
         cyc(6);
         wr(OFS_EXT_FLAG + g, 32'h0);
         setpin(rows[i].rise);
         cyc(6);
         rd(OFS_EXT_FLAG + g, fx | 32'(rows[i].exp) << rows[i].idx);
         wr(OFS_EXT_FLAG + g, 32'hffffffff);
         rd(OFS_EXT_FLAG + g, fx | 32'(rows[i].exp) << rows[i].idx);
         wr(OFS_EXT_FLAG + g, 32'h0);
         rd(OFS_EXT_FLAG + g, fx);
         $display("row %0d done", i);
      end
      wr(OFS_EXT_EDGE, 32'h0);
      @(posedge clock);
      ext_req_pin <= 4'hf;
      wr(OFS_PORT_A, 32'hf);
      cyc(6);
      wr(OFS_EXT_FLAG, 32'h0);
      wr(OFS_IRQ_EN, 32'h6);
      @(posedge clock);
      ext_req_pin <= 4'h9;
      cyc(6);
      rd(OFS_EXT_FLAG, 32'h6);
      idle_chk();
      unmask(1'b0);
      accept(SRC_EXT0 + 4'h1);
      wr(OFS_EXT_FLAG, 32'hd);
      rd(OFS_EXT_FLAG, 32'h4);
      unmask(1'b1);
      accept(SRC_EXT0 + 4'h2);
      wr(OFS_IRQ_EN, 32'h0);
      wr(OFS_WAKE_EDGE, 32'h0);
      @(posedge clock);
      wake_pin <= 6'h3f;
      wr(OFS_PORT_B, 32'h1);
      cyc(6);
      wr(OFS_WAKE_FLAG, 32'h0);
      @(posedge clock);
      wake_pin <= 6'h3e;
      unmask(1'b0);
      idle_chk();
      wr(OFS_IRQ_EN, 32'h20);
      accept(SRC_WAKE);
      wr(OFS_WAKE_FLAG, 32'h0);
      wr(OFS_PER_EN, 32'h8);
      @(posedge clock);
      periph_req <= 8'h08;
      @(posedge clock);
      periph_req <= 8'h00;
      rd(OFS_PER_FLAG, 32'h8);
      unmask(1'b0);
      accept(SRC_PER0 + 4'h3);
      wr(OFS_BRK_ADDR, 32'h0abc);
      wr(OFS_BRK_CTRL, 32'h80);
      @(posedge clock);
      bus_addr <= 16'h0abc;
      bus_exec <= 1'b1;
      @(posedge clock);
      bus_exec <= 1'b0;
      accept(SRC_BRK);
      wr(OFS_BRK_STAT, 32'h0);
      summarize();
   end
endmodule // mic_intc_tb_top
`default_nettype wire
